// File: debug_enclave_read_leaf.sv
// Debug enclave read leaf: checks a source address against the page cache map and
// returns one word from an external memory port. Registers sit on AHB-Lite.
// Assumes one AHB-Lite master, single word transfers, and a same-clock memory port.
//
// Functional notes
// (RQ1) The read runs only when the function code written is 04H.
// (RQ2) Eight bytes land in data in wide mode, else only the low four.
// (RQ3) Wide mode holds only when long-mode-active and code-segment long are both 1.
// (RQ4) Misalignment (8 bytes wide, 4 otherwise) gives a protection fault first.
// (RQ5) Address outside the page cache gives a page fault reporting it.
// (RQ6) A concurrent modifier of the same map entry gives a protection fault.
// (RQ7) An invalid map entry gives a page fault reporting the address.
// (RQ8) Only regular, thread, version-array and shadow-stack types; others page fault.
// (RQ9) Pending or modified page: zero flag set, error code, no data moved.
// (RQ10) Thread page offset at or beyond the size limit gives protection fault.
// (RQ11) Regular or thread page of a non-debug owner gives protection fault.
// (RQ12) Passing regular or thread read copies the memory word at mode width.
// (RQ13) Other types: low three bits cleared, nonzero returns all ones, else zero.
// (RQ14) Success writes zero to the result and clears the zero flag.
// (RQ15) Every non-faulting completion clears carry, parity, aux, overflow, sign.
// (RQ16) Read, write and execute permissions in the entry are never checked.
// (RQ17) Any operand segment violation gives a protection fault.
// (RQ18) Non-canonical address in wide mode gives a protection fault.
// (RQ19) Regular or thread pages of non-debug enclaves fault and their data never returns.
// (RQ20) Privilege level above zero gives a protection fault.
`default_nettype none

module debug_enclave_read_leaf
   import debug_read_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   output logic             MEM_REQ,
   output logic      [63:0] MEM_ADDR,
   input  wire logic        MEM_ACK,
   input  wire logic [63:0] MEM_RDATA,
   output logic             OP_DONE
);

   // Bus phase tracking.
   logic                    wr_pend_r;
   logic                    rd_pend_r;
   logic [7:0]              bus_addr_r;
   logic [31:0]             hrdata_r;
   logic                    hready_r;

   // Software visible state.
   logic [31:0]             result_r;
   logic [63:0]             addr_r;
   logic [5:0]              ctrl_r;
   logic [63:0]             data_r;
   logic [31:0]             flags_r;
   logic [1:0]              fault_r;
   logic [63:0]             faddr_r;
   logic [IDX_W-1:0]        map_idx_r;
   logic [ENT_W-1:0]        map_mem [PAGES];

   // Operation state.
   state_t                  state_r;
   logic                    mode64_r;
   logic                    mem_req_r;
   logic                    op_done_r;

   function automatic logic is_reg_or_thread(input logic [2:0] t);
      is_reg_or_thread = (t == REGULAR_PAGE_TYPE) || (t == THREAD_PAGE_TYPE);
   endfunction : is_reg_or_thread

   function automatic logic type_accepted(input logic [2:0] t);
      type_accepted = is_reg_or_thread(t) || (t == VERSION_ARRAY_PAGE_TYPE) ||
                      (t == SHADOW_STACK_FIRST_PAGE_TYPE) ||
                      (t == SHADOW_STACK_REST_PAGE_TYPE);
   endfunction : type_accepted

   // Address phase decode.
   wire             addr_phase = HSEL && HREADY && HTRANS[1];
   wire             wr_go      = wr_pend_r && (bus_addr_r == OFS_GO) && HWDATA[0];
   wire             wr_result  = wr_pend_r && (bus_addr_r == OFS_RESULT);
   wire             wr_flags   = wr_pend_r && (bus_addr_r == OFS_FLAGS);
   wire             wr_map     = wr_pend_r && (bus_addr_r == OFS_MAP_ENTRY);
   wire             busy       = (state_r != ST_IDLE);

   // Mode select and the start condition.
   wire             mode64_now = ctrl_r[CTRL_LMA] && ctrl_r[CTRL_CSL];  // RQ3
   wire             start      = wr_go && !busy && (result_r == LEAF_DEBUG_READ);  // RQ1

   // Check decode for the latched source address.
   wire [ENT_W-1:0] entry      = map_mem[addr_r[IDX_W+11:12]];
   wire [2:0]       ent_type   = entry[ENT_TYPE +: 3];
   wire             in_cache   = (addr_r[63:IDX_W+12] == CACHE_BASE[63:IDX_W+12]);
   wire             misaligned = mode64_r ? (addr_r[2:0] != 3'h0) : (addr_r[1:0] != 2'h0);
   wire             noncanon   = mode64_r &&
                                 (addr_r[63:VA_BITS-1] != {(65-VA_BITS){addr_r[VA_BITS-1]}});
   wire             priv_bad   = (ctrl_r[CTRL_PRIV +: 2] != 2'h0);
   wire             pre_gp     = priv_bad || ctrl_r[CTRL_SEG] || noncanon || misaligned;
   wire             pend_mod   = entry[ENT_PEND] || entry[ENT_MOD];
   wire             over_limit = (ent_type == THREAD_PAGE_TYPE) &&
                                 (addr_r[11:0] >= THREAD_STRUCTURE_SIZE_LIMIT);
   wire             no_debug   = is_reg_or_thread(ent_type) && !entry[ENT_DEBUG];

   // Ordered outcome of the checking cycle; permission bits never take part.  RQ16
   wire             chk_gp_a   = pre_gp;                                  // RQ4 RQ17 RQ18 RQ20
   wire             chk_pf_a   = !chk_gp_a && !in_cache;                  // RQ5
   wire             chk_gp_b   = !chk_gp_a && in_cache && ctrl_r[CTRL_CONF];  // RQ6
   wire             pass_conf  = !chk_gp_a && in_cache && !ctrl_r[CTRL_CONF];
   wire             chk_pf_b   = pass_conf && (!entry[ENT_VALID] || !type_accepted(ent_type));
   wire             pass_type  = pass_conf && entry[ENT_VALID] && type_accepted(ent_type);
   wire             chk_nodbg  = pass_type && pend_mod;                   // RQ9
   wire             chk_gp_c   = pass_type && !pend_mod && (over_limit || no_debug);  // RQ10 RQ11
   wire             chk_fetch  = pass_type && !pend_mod && !over_limit && !no_debug;
   wire             chk_gp     = chk_gp_a || chk_gp_b || chk_gp_c;
   wire             chk_pf     = chk_pf_a || chk_pf_b;                    // RQ7 RQ8

   // Data returned when the memory answers.
   wire             fetch_done = (state_r == ST_FETCH) && MEM_ACK;
   wire [63:0]      masked     = MEM_RDATA & ~LOW3_MASK;
   wire [63:0]      summary    = (masked != 64'h0) ? {64{1'b1}} : 64'h0;  // RQ13
   wire [63:0]      word       = is_reg_or_thread(ent_type) ? MEM_RDATA : summary;  // RQ12
   wire [63:0]      data_nxt   = mode64_r ? word : {data_r[63:32], word[31:0]};  // RQ2

   // Read selection.
   wire [31:0]      rd_mux =
      (bus_addr_r == OFS_RESULT)    ? result_r :
      (bus_addr_r == OFS_ADDR_LO)   ? addr_r[31:0] :
      (bus_addr_r == OFS_ADDR_HI)   ? addr_r[63:32] :
      (bus_addr_r == OFS_CTRL)      ? {26'h0, ctrl_r} :
      (bus_addr_r == OFS_GO)        ? {31'h0, busy} :
      (bus_addr_r == OFS_DATA_LO)   ? data_r[31:0] :
      (bus_addr_r == OFS_DATA_HI)   ? data_r[63:32] :
      (bus_addr_r == OFS_FLAGS)     ? flags_r :
      (bus_addr_r == OFS_FAULT)     ? {30'h0, fault_r} :
      (bus_addr_r == OFS_FADDR_LO)  ? faddr_r[31:0] :
      (bus_addr_r == OFS_FADDR_HI)  ? faddr_r[63:32] :
      (bus_addr_r == OFS_MAP_IDX)   ? {{(32-IDX_W){1'b0}}, map_idx_r} :
      (bus_addr_r == OFS_MAP_ENTRY) ? {{(32-ENT_W){1'b0}}, map_mem[map_idx_r]} :
      32'h0;

   // Bus slave: writes take no wait state, reads take one.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         wr_pend_r  <= 1'b0;
         rd_pend_r  <= 1'b0;
         bus_addr_r <= 8'h00;
         hrdata_r   <= 32'h0;
         hready_r   <= 1'b1;
      end
      else
      begin
         wr_pend_r <= addr_phase && HWRITE;
         rd_pend_r <= addr_phase && !HWRITE;
         hready_r  <= !(addr_phase && !HWRITE);
         if (addr_phase)
         begin
            bus_addr_r <= {HADDR[7:2], 2'b00};
         end
         if (rd_pend_r)
         begin
            hrdata_r <= rd_mux;
         end
      end
   end

   // Software registers; bus writes are ignored while an operation is busy.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         addr_r    <= 64'h0;
         ctrl_r    <= CTRL_RESET;
         map_idx_r <= '0;
      end
      else if (wr_pend_r && !busy)
      begin
         if (bus_addr_r == OFS_ADDR_LO)
         begin
            addr_r[31:0] <= HWDATA;
         end
         if (bus_addr_r == OFS_ADDR_HI)
         begin
            addr_r[63:32] <= HWDATA;
         end
         if (bus_addr_r == OFS_CTRL)
         begin
            ctrl_r <= HWDATA[5:0];
         end
         if (bus_addr_r == OFS_MAP_IDX)
         begin
            map_idx_r <= HWDATA[IDX_W-1:0];
         end
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         for (int i = 0; i < PAGES; i++)
         begin
            map_mem[i] <= '0;
         end
      end
      else if (wr_map && !busy)
      begin
         map_mem[map_idx_r] <= HWDATA[ENT_W-1:0];
      end
   end

   // Operation sequencer.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state_r   <= ST_IDLE;
         mode64_r  <= 1'b0;
         mem_req_r <= 1'b0;
         op_done_r <= 1'b0;
         result_r  <= 32'h0;
         data_r    <= 64'h0;
         flags_r   <= FLAGS_RESET;
         fault_r   <= 2'b00;
         faddr_r   <= 64'h0;
      end
      else
      begin
         op_done_r <= 1'b0;
         if (wr_result && !busy)
         begin
            result_r <= HWDATA;
         end
         if (wr_flags && !busy)
         begin
            flags_r <= HWDATA;
         end
         case (state_r)
            ST_IDLE:
            begin
               if (start)
               begin
                  mode64_r <= mode64_now;
                  fault_r  <= 2'b00;
                  state_r  <= ST_CHECK;
               end
            end
            ST_CHECK:
            begin
               if (chk_gp)
               begin
                  fault_r[FLT_GP] <= 1'b1;
                  op_done_r       <= 1'b1;
                  state_r         <= ST_IDLE;
               end
               else if (chk_pf)
               begin
                  fault_r[FLT_PF] <= 1'b1;
                  faddr_r         <= addr_r;
                  op_done_r       <= 1'b1;
                  state_r         <= ST_IDLE;
               end
               else if (chk_nodbg)
               begin
                  result_r  <= PAGE_NOT_DEBUGGABLE_ERROR;        // RQ9
                  flags_r   <= (flags_r & ~FLAGS_CLR) | (32'h1 << FLG_ZERO);  // RQ15
                  op_done_r <= 1'b1;
                  state_r   <= ST_IDLE;
               end
               else if (chk_fetch)
               begin
                  mem_req_r <= 1'b1;
                  state_r   <= ST_FETCH;
               end
               else
               begin
                  state_r <= ST_IDLE;
               end
            end
            ST_FETCH:
            begin
               if (MEM_ACK)
               begin
                  mem_req_r <= 1'b0;
                  data_r    <= data_nxt;                        // RQ12 RQ19
                  result_r  <= 32'h0;                           // RQ14
                  flags_r   <= flags_r & ~FLAGS_CLR;            // RQ14 RQ15
                  op_done_r <= 1'b1;
                  state_r   <= ST_IDLE;
               end
            end
            default:
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   assign HRDATA    = hrdata_r;
   assign HREADYOUT = hready_r;
   assign HRESP     = 1'b0;
   assign MEM_REQ   = mem_req_r;
   assign MEM_ADDR  = addr_r;
   assign OP_DONE   = op_done_r;

   AST_ALIGN_GP: assert property (@(posedge CLK) disable iff (RST) // RQ4
      (state_r == ST_CHECK) && mode64_r && (addr_r[2:0] != 3'h0)
      |=> fault_r[FLT_GP] && !fault_r[FLT_PF] && OP_DONE)
      else $error("Misaligned wide read did not raise a protection fault.");

   AST_PRIV_GP: assert property (@(posedge CLK) disable iff (RST) // RQ20
      (state_r == ST_CHECK) && priv_bad |=> fault_r[FLT_GP] && (state_r == ST_IDLE))
      else $error("Nonzero privilege level did not fault.");

   AST_OUTSIDE_PF: assert property (@(posedge CLK) disable iff (RST) // RQ5
      (state_r == ST_CHECK) && !pre_gp && !in_cache
      |=> fault_r[FLT_PF] && (faddr_r == $past(addr_r)))
      else $error("Address outside the page cache did not page fault with its address.");

   AST_NOT_DEBUGGABLE: assert property (@(posedge CLK) disable iff (RST) // RQ9
      (state_r == ST_CHECK) && chk_nodbg
      |=> flags_r[FLG_ZERO] && (result_r == PAGE_NOT_DEBUGGABLE_ERROR) && !MEM_REQ
          && $stable(data_r))
      else $error("Pending or modified page was not reported as not debuggable.");

   AST_NODEBUG_GP: assert property (@(posedge CLK) disable iff (RST) // RQ11
      (state_r == ST_CHECK) && pass_type && !pend_mod && no_debug
      |=> fault_r[FLT_GP] ##1 !MEM_REQ)
      else $error("Non-debug owner did not raise a protection fault.");

   AST_SUCCESS: assert property (@(posedge CLK) disable iff (RST) // RQ14
      fetch_done |=> (result_r == 32'h0) && !flags_r[FLG_ZERO] && OP_DONE)
      else $error("Successful read did not clear result and zero flag.");

   AST_FLAGS_CLEARED: assert property (@(posedge CLK) disable iff (RST) // RQ15
      OP_DONE && (fault_r == 2'b00) |-> ((flags_r & FLAGS_CLR & ~(32'h1 << FLG_ZERO)) == 32'h0))
      else $error("Completion left arithmetic flags set.");

   AST_VA_SUMMARY: assert property (@(posedge CLK) disable iff (RST) // RQ13
      fetch_done && mode64_r && !is_reg_or_thread(ent_type)
      |=> (data_r == (($past(MEM_RDATA) & ~LOW3_MASK) != 64'h0 ? {64{1'b1}} : 64'h0)))
      else $error("Version array summary value is wrong.");

   AST_NARROW_KEEPS_HIGH: assert property (@(posedge CLK) disable iff (RST) // RQ2
      fetch_done && !mode64_r
      |=> (data_r[63:32] == $past(data_r[63:32])) && (data_r[31:0] == $past(word[31:0])))
      else $error("Narrow read touched the upper data half.");

   AST_WIDE_COPY: assert property (@(posedge CLK) disable iff (RST) // RQ12
      fetch_done && mode64_r && is_reg_or_thread(ent_type) |=> data_r == $past(MEM_RDATA))
      else $error("Wide read did not copy the memory word.");

   AST_FAULT_NO_DATA: assert property (@(posedge CLK) disable iff (RST) // RQ19
      (state_r == ST_CHECK) && (chk_gp || chk_pf) |=> $stable(data_r) && !MEM_REQ)
      else $error("Faulting read changed the data register.");

   AST_INVALID_PF: assert property (@(posedge CLK) disable iff (RST) // RQ7
      (state_r == ST_CHECK) && pass_conf && !entry[ENT_VALID]
      |=> fault_r[FLT_PF] && (faddr_r == $past(addr_r)) && OP_DONE)
      else $error("Invalid map entry did not page fault with its address.");

   AST_TYPE_PF: assert property (@(posedge CLK) disable iff (RST) // RQ8
      (state_r == ST_CHECK) && pass_conf && entry[ENT_VALID] && !type_accepted(ent_type)
      |=> fault_r[FLT_PF] && !fault_r[FLT_GP] && !MEM_REQ)
      else $error("Refused page type did not page fault.");

   AST_LIMIT_GP: assert property (@(posedge CLK) disable iff (RST) // RQ10
      (state_r == ST_CHECK) && pass_type && !pend_mod && over_limit
      |=> fault_r[FLT_GP] && OP_DONE && !MEM_REQ)
      else $error("Thread page offset beyond the size limit did not fault.");

endmodule : debug_enclave_read_leaf

`default_nettype wire

// File: debug_enclave_read_leaf_tb.sv
// Self-checking bench for the debug enclave read leaf, driven over AHB-Lite.
// Assumes mem_port_model as the memory behind the block's word port.
`default_nettype none

module debug_enclave_read_leaf_tb;
   import debug_read_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        CLK;
   logic        RST;
   logic        HSEL;
   logic        HWRITE;
   logic [1:0]  HTRANS;
   logic [2:0]  HSIZE;
   logic [31:0] HADDR;
   logic [31:0] HWDATA;
   logic [31:0] HRDATA;
   logic        HREADYOUT;
   logic        HRESP;
   logic        MEM_REQ;
   logic [63:0] MEM_ADDR;
   logic        MEM_ACK;
   logic [63:0] MEM_RDATA;
   logic        OP_DONE;
   wire logic   HREADY = HREADYOUT;
   logic [63:0] mem_word;
   logic [3:0]  mem_dly;
   logic [63:0] last_addr;
   int          n_errors = 0;
   int          total_checks = 0;
   int          n_mem = 0;
   int          moved = 0;
   int          cyc = 0;

   debug_enclave_read_leaf debug_enclave_read_leaf_i (.CLK, .RST, .HSEL, .HADDR, .HTRANS,
      .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .MEM_REQ, .MEM_ADDR,
      .MEM_ACK, .MEM_RDATA, .OP_DONE);

   mem_port_model mem_port_model_i (.clk(CLK), .rst(RST), .mem_req(MEM_REQ), .word(mem_word),
      .delay(mem_dly), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));

   initial
   begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end

   always @(posedge CLK)
   begin
      cyc++;
      if (MEM_REQ === 1'b1 && MEM_ACK === 1'b1)
      begin
         n_mem++;
         last_addr = MEM_ADDR;
      end
      if (cyc == 20000)
      begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic print_verdict;
      if (n_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      HTRANS <= 2'b10;
      HADDR  <= {24'h0, a};
      HWRITE <= 1'b1;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
   endtask : bw

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge CLK);
      HTRANS <= 2'b10;
      HADDR  <= {24'h0, a};
      HWRITE <= 1'b0;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'b00;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      chk({32'h0, HRDATA}, {32'h0, exp});
      chk({63'h0, HRESP}, 64'h0);
   endtask : rchk

   function automatic logic [31:0] ent(input logic [2:0] t, input logic [1:0] pm,
                                       input logic dbg, input logic [2:0] p);
      return {22'h0, p, dbg, pm, t, 1'b1};
   endfunction : ent

   // Counts completion pulses over a window longer than the slowest answer.
   task automatic run_op(input logic [63:0] a, input logic [31:0] ctl,
                         input logic [31:0] e, input logic [31:0] code);
      int n0;
      int nd;
      n0 = n_mem;
      nd = 0;
      bw(OFS_MAP_IDX, {29'h0, a[14:12]});
      bw(OFS_MAP_ENTRY, e);
      bw(OFS_ADDR_LO, a[31:0]);
      bw(OFS_ADDR_HI, a[63:32]);
      bw(OFS_CTRL, ctl);
      bw(OFS_FLAGS, 32'h0000_08d7);
      bw(OFS_RESULT, code);
      bw(OFS_GO, 32'h0000_0001);
      repeat (40)
      begin
         @(posedge CLK);
         nd += int'(OP_DONE === 1'b1);
      end
      moved = n_mem - n0;
      chk(64'(nd), (code === LEAF_DEBUG_READ) ? 64'h1 : 64'h0);
   endtask : run_op

   task automatic fcase(input logic [63:0] a, input logic [31:0] ctl,
                        input logic [31:0] e, input logic [31:0] f);
      run_op(a, ctl, e, LEAF_DEBUG_READ);
      rchk(OFS_FAULT, f);
      rchk(OFS_RESULT, LEAF_DEBUG_READ);
      rchk(OFS_FLAGS, 32'h0000_08d7);
      chk(64'(moved), 64'h0);
      if (f == 32'h2)
      begin
         rchk(OFS_FADDR_LO, a[31:0]);
         rchk(OFS_FADDR_HI, a[63:32]);
      end
   endtask : fcase

   task automatic t_success;
      mem_word <= 64'h1122_3344_5566_7788;
      mem_dly  <= 4'h5;
      run_op(64'h8000_1008, 32'h3, ent(REGULAR_PAGE_TYPE, 2'b00, 1'b1, 3'h0), LEAF_DEBUG_READ);
      chk(64'(moved), 64'h1);
      chk(last_addr, 64'h8000_1008);
      rchk(OFS_RESULT, 32'h0);
      rchk(OFS_FLAGS, 32'h0000_0002);
      rchk(OFS_FAULT, 32'h0);
      rchk(OFS_DATA_LO, 32'h5566_7788);
      rchk(OFS_DATA_HI, 32'h1122_3344);
      mem_word <= 64'haabb_ccdd_0102_0304;
      mem_dly  <= 4'h0;
      run_op(64'h8000_2004, 32'h2, ent(THREAD_PAGE_TYPE, 2'b00, 1'b1, 3'h7), LEAF_DEBUG_READ);
      rchk(OFS_DATA_LO, 32'h0102_0304);
      rchk(OFS_DATA_HI, 32'h1122_3344);
      run_op(64'h8000_20f8, 32'h3, ent(THREAD_PAGE_TYPE, 2'b00, 1'b1, 3'h0), LEAF_DEBUG_READ);
      rchk(OFS_FAULT, 32'h0);
      rchk(OFS_DATA_HI, 32'haabb_ccdd);
   endtask : t_success

   task automatic t_faults;
      logic [31:0] r;
      r = ent(REGULAR_PAGE_TYPE, 2'b00, 1'b1, 3'h0);
      fcase(64'h8000_3000, 32'h7, r, 32'h1);
      fcase(64'h8000_3000, 32'h13, r, 32'h1);
      fcase(64'h0001_0000_8000_3000, 32'h3, r, 32'h1);
      fcase(64'h8000_3004, 32'h3, r, 32'h1);
      fcase(64'h8000_3002, 32'h0, r, 32'h1);
      fcase(64'h9000_0004, 32'h3, r, 32'h1);
      fcase(64'h9000_0000, 32'h3, r, 32'h2);
      fcase(64'h8000_3000, 32'h23, r, 32'h1);
      fcase(64'h8000_3000, 32'h3, r & 32'hffff_fffe, 32'h2);
      fcase(64'h8000_3000, 32'h3, ent(CONTROL_PAGE_TYPE, 2'b00, 1'b1, 3'h0), 32'h2);
      fcase(64'h8000_3000, 32'h3, ent(TRIM_PAGE_TYPE, 2'b00, 1'b1, 3'h0), 32'h2);
      fcase(64'h8000_3000, 32'h3, ent(3'h7, 2'b00, 1'b1, 3'h0), 32'h2);
      fcase(64'h8000_3100, 32'h3, ent(THREAD_PAGE_TYPE, 2'b00, 1'b1, 3'h0), 32'h1);
      fcase(64'h8000_3000, 32'h3, ent(REGULAR_PAGE_TYPE, 2'b00, 1'b0, 3'h7), 32'h1);
      fcase(64'h8000_3008, 32'h1, ent(THREAD_PAGE_TYPE, 2'b00, 1'b0, 3'h0), 32'h1);
   endtask : t_faults

   task automatic t_pending;
      for (int i = 1; i < 4; i++)
      begin
         run_op(64'h8000_4000, 32'h3, ent(REGULAR_PAGE_TYPE, 2'(i), 1'b1, 3'h0),
                LEAF_DEBUG_READ);
         chk(64'(moved), 64'h0);
         rchk(OFS_RESULT, PAGE_NOT_DEBUGGABLE_ERROR);
         rchk(OFS_FLAGS, 32'h0000_0042);
      end
   endtask : t_pending

   task automatic summ(input logic [2:0] t, input logic [31:0] ctl, input logic [63:0] w,
                       input logic [31:0] lo, input logic [31:0] hi);
      mem_word <= w;
      run_op(64'h8000_5000, ctl, ent(t, 2'b00, 1'b0, 3'h0), LEAF_DEBUG_READ);
      rchk(OFS_RESULT, 32'h0);
      rchk(OFS_DATA_LO, lo);
      rchk(OFS_DATA_HI, hi);
   endtask : summ

   task automatic t_summary;
      summ(VERSION_ARRAY_PAGE_TYPE, 32'h3, 64'h8, 32'hffff_ffff, 32'hffff_ffff);
      summ(VERSION_ARRAY_PAGE_TYPE, 32'h3, 64'h7, 32'h0, 32'h0);
      summ(SHADOW_STACK_FIRST_PAGE_TYPE, 32'h0, 64'h1_0000_0000, 32'hffff_ffff, 32'h0);
      summ(SHADOW_STACK_REST_PAGE_TYPE, 32'h1, 64'h7, 32'h0, 32'h0);
   endtask : t_summary

   task automatic t_refuse;
      run_op(64'h8000_1008, 32'h3, ent(REGULAR_PAGE_TYPE, 2'b00, 1'b1, 3'h0), 32'h5);
      chk(64'(moved), 64'h0);
      rchk(OFS_GO, 32'h0);
   endtask : t_refuse

   initial
   begin
      RST      = 1'b1;
      HSEL     = 1'b1;
      HSIZE    = 3'b010;
      HTRANS   = 2'b00;
      HWRITE   = 1'b0;
      HADDR    = 32'h0;
      HWDATA   = 32'h0;
      mem_word = 64'h0;
      mem_dly  = 4'h0;
      repeat (5) @(posedge CLK);
      RST <= 1'b0;
      t_success();
      t_faults();
      t_pending();
      t_summary();
      t_refuse();
      print_verdict();
   end
endmodule : debug_enclave_read_leaf_tb

`default_nettype wire

// File: debug_read_pkg.sv
// Constants shared by the debug enclave read block: register map, fields, codes.
// Assumes a 32-bit AHB-Lite bus with word-aligned register offsets.
`default_nettype none

package debug_read_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_RESULT     = 8'h00;
   localparam logic [7:0] OFS_ADDR_LO    = 8'h04;
   localparam logic [7:0] OFS_ADDR_HI    = 8'h08;
   localparam logic [7:0] OFS_CTRL       = 8'h0c;
   localparam logic [7:0] OFS_GO         = 8'h10;
   localparam logic [7:0] OFS_DATA_LO    = 8'h14;
   localparam logic [7:0] OFS_DATA_HI    = 8'h18;
   localparam logic [7:0] OFS_FLAGS      = 8'h1c;
   localparam logic [7:0] OFS_FAULT      = 8'h20;
   localparam logic [7:0] OFS_FADDR_LO   = 8'h24;
   localparam logic [7:0] OFS_FADDR_HI   = 8'h28;
   localparam logic [7:0] OFS_MAP_IDX    = 8'h2c;
   localparam logic [7:0] OFS_MAP_ENTRY  = 8'h30;

   // Control register fields.
   localparam int CTRL_LMA   = 0;
   localparam int CTRL_CSL   = 1;
   localparam int CTRL_PRIV  = 2;
   localparam int CTRL_SEG   = 4;
   localparam int CTRL_CONF  = 5;
   localparam logic [5:0] CTRL_RESET = 6'h00;

   // Flag bit positions in the flags register.
   localparam int FLG_CF = 0;
   localparam int FLG_PF = 2;
   localparam int FLG_AF = 4;
   localparam int FLG_ZERO = 6;
   localparam int FLG_SF = 7;
   localparam int FLG_OF = 11;
   localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
   localparam logic [31:0] FLAGS_CLR   = 32'h0000_08d5;

   // Fault register fields.
   localparam int FLT_GP = 0;
   localparam int FLT_PF = 1;

   // Page map entry fields.
   localparam int ENT_VALID = 0;
   localparam int ENT_TYPE  = 1;
   localparam int ENT_PEND  = 4;
   localparam int ENT_MOD   = 5;
   localparam int ENT_DEBUG = 6;
   localparam int ENT_PERM  = 7;
   localparam int ENT_W     = 10;

   // Protected page cache placement: eight 4 KiB pages.
   localparam int         PAGES      = 8;
   localparam int         IDX_W      = 3;
   localparam logic [63:0] CACHE_BASE = 64'h0000_0000_8000_0000;
   localparam int         VA_BITS    = 48;

   // Codes.
   localparam logic [31:0] LEAF_DEBUG_READ           = 32'h0000_0004;
   localparam logic [31:0] PAGE_NOT_DEBUGGABLE_ERROR = 32'h0000_000e;
   localparam logic [11:0] THREAD_STRUCTURE_SIZE_LIMIT = 12'h100;
   localparam logic [63:0] LOW3_MASK = 64'h0000_0000_0000_0007;

   typedef enum logic [2:0]
   {
      REGULAR_PAGE_TYPE            = 3'b000,
      THREAD_PAGE_TYPE             = 3'b001,
      VERSION_ARRAY_PAGE_TYPE      = 3'b010,
      CONTROL_PAGE_TYPE            = 3'b011,
      TRIM_PAGE_TYPE               = 3'b100,
      SHADOW_STACK_FIRST_PAGE_TYPE = 3'b101,
      SHADOW_STACK_REST_PAGE_TYPE  = 3'b110
   } page_type_t;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_CHECK = 2'b01,
      ST_FETCH = 2'b10
   } state_t;

endpackage : debug_read_pkg

`default_nettype wire

// File: mem_port_model.sv
// Memory port partner for the debug enclave read leaf: answers each word request.
// Assumes one clock shared with the block; the bench sets the word and the delay.
`default_nettype none

module mem_port_model
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        mem_req,
   input  wire logic [63:0] word,
   input  wire logic [3:0]  delay,
   output logic             mem_ack,
   output logic      [63:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] cnt_r;

   // Read data is good only in the acknowledge cycle; elsewhere it toggles.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_r     <= 4'h0;
         mem_ack   <= 1'b0;
         mem_rdata <= 64'h0;
      end
      else if (mem_req && !mem_ack && cnt_r == delay)
      begin
         cnt_r     <= 4'h0;
         mem_ack   <= 1'b1;
         mem_rdata <= word;
      end
      else
      begin
         cnt_r     <= (mem_req && !mem_ack) ? cnt_r + 4'h1 : 4'h0;
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : mem_port_model

`default_nettype wire
